// File: rtl/adc_dma_capture.sv
// Converter sequencer with DMA capture of results into data memory.
// Assumes a static RAM whose read data is valid one cycle after the read strobe.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps

// Overview of operation
// R1: Conversion is fifteen approximation clocks, one sync clock, one to four acquisition.
// R2: Converter clock is master clock divided by one of four ratios, bits 5:4.
// R3: Software keeps converter clock between 400 kHz and 6 MHz.
// R4: Continuous mode restarts a conversion the moment the previous one ends.
// R5: Software uses divide by 32 and four acquisition clocks for temperature.
// R6: Control two bit 6 enables DMA storing results into data memory.
// R7: DMA sustains back-to-back conversions at the full converter rate.
// R8: Software powers the converter down before setting up DMA.
// R9: Software loads pointer low, then high, then page.
// R10: Software stores channel identifiers in upper nibble of every second location.
// R11: Last identifier repeated then 1111; 1111 stops the run.
// R12: Software enables DMA, then configures control one, then triggers.
// R13: DMA conversions start by single start, timer 2 overflow or external trigger.
// R14: Run completion sets the conversion done flag.
// R15: The final two list locations are never written.
// R16: During DMA to external memory, core external memory accesses have no effect.
// R17: Each cycle converts the fetched channel, writes prior result, reads next channel.
// R18: The first valid result is written in the third DMA cycle.
// R19: DMA to external memory blocks core ports; DMA to internal leaves them usable.
// R20: Core reaches internal RAM during DMA only if enabled and destination external.
// R21: Result stored as channel and bits 11:8, then bits 7:0.
// R22: After the stop pattern, conversions stop and memory returns to the core.
module adc_dma_capture
	import adc_dma_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire avmm_req_t   avs_req,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        timer2_overflow,
	input  wire logic        ext_trigger,
	input  wire logic [11:0] adc_data,
	output logic [3:0]       adc_channel,
	output logic             adc_busy,
	output mem_bus_t         mem,
	input  wire logic [7:0]  mem_rdata,
	output logic             core_ext_enable,
	output logic             core_int_enable
);

	// ==========================================================
	// State
	logic [7:0]  ctrl_one_reg, ctrl_two_reg, ptr_low_reg, ptr_high_reg, ptr_page_reg;
	logic [1:0]  mem_cfg_reg;
	logic        done_reg, wait_reg;
	logic [31:0] rdata_reg;
	logic [5:0]  div_cnt_reg;
	logic        tick_reg;
	logic        conv_active_reg, pend_reg, free_run_reg;
	logic [4:0]  tick_cnt_reg;
	logic [11:0] result_reg;
	logic [3:0]  conv_chan_reg, next_chan_reg, wr_chan_reg;
	logic [11:0] wr_res_reg;
	logic        dma_run_reg, conv_valid_reg, fetch_valid_reg, wr_valid_reg, stop_seen_reg;
	logic [23:0] rd_addr_reg, wr_addr_reg;
	mem_state_t  mst_reg, mst_next;
	mem_bus_t    mem_reg, mem_next;
	logic        ext_en_reg, int_en_reg;

	// ==========================================================
	// Decode and sequencing terms
	wire         bus_req    = avs_req.read | avs_req.write;
	wire         bus_wr     = avs_req.write & ~wait_reg & avs_req.byteenable[0];
	wire [7:0]   wbyte      = avs_req.writedata[7:0];
	wire         wr_c1      = bus_wr & (avs_req.address == REG_CTRL_ONE);
	wire         wr_c2      = bus_wr & (avs_req.address == REG_CTRL_TWO);
	wire         wr_st      = bus_wr & (avs_req.address == REG_STATUS);
	wire         single_req = wr_c2 & wbyte[C2_SINGLE];
	wire         power_on   = ctrl_one_reg[C1_POWER];
	wire         dma_en     = ctrl_two_reg[C2_DMA_EN];
	wire         dma_int    = mem_cfg_reg[MC_DMA_INT];
	wire [5:0]   div_val    = div_ratio(ctrl_one_reg[C1_DIV_LO +: 2]);
	// Acquisition field 0..3 means 1..4 clocks
	wire [4:0]   acq_clks   = {3'h0, ctrl_one_reg[C1_ACQ_LO +: 2]} + 5'h01;
	wire [4:0]   conv_len   = APPROX_CLKS + SYNC_CLKS + acq_clks; // [R1]
	wire         conv_end   = conv_active_reg & tick_reg & (tick_cnt_reg == conv_len - 5'h01);
	wire         start_req  = single_req                                   // [R13]
	                        | (timer2_overflow & ctrl_one_reg[C1_T2_EN])
	                        | (ext_trigger & ctrl_one_reg[C1_EXT_EN]);
	wire         stop_now   = dma_run_reg & stop_seen_reg & conv_end;     // [R22] [R15]
	wire         auto_again = ctrl_two_reg[C2_CONT] | free_run_reg;
	wire         restart    = conv_end & auto_again & ~stop_now;           // [R4] [R7]
	wire         want       = pend_reg | start_req | restart;
	wire         conv_begin = want & power_on & ~stop_now & (mst_reg == M_IDLE)
	                        & (~conv_active_reg | conv_end);
	wire         dma_begin  = conv_begin & dma_en;                         // [R6]
	// Result of the conversion that is closing this cycle
	wire [11:0]  fin_res    = conv_end ? adc_data : result_reg;
	wire         wr_now     = dma_begin & dma_run_reg & conv_valid_reg;    // [R18]

	// ==========================================================
	// Avalon slave: one wait cycle, then the answer; unmapped reads zero
	logic [31:0] rdata_next;
	always_comb
	begin
		case (avs_req.address)
			REG_CTRL_ONE: rdata_next = {24'h0, ctrl_one_reg};
			REG_CTRL_TWO: rdata_next = {24'h0, ctrl_two_reg};
			REG_PTR_LOW:  rdata_next = {24'h0, ptr_low_reg};
			REG_PTR_HIGH: rdata_next = {24'h0, ptr_high_reg};
			REG_PTR_PAGE: rdata_next = {24'h0, ptr_page_reg};
			REG_STATUS:   rdata_next = {29'h0, dma_run_reg, conv_active_reg, done_reg};
			REG_RESULT:   rdata_next = {16'h0, conv_chan_reg, result_reg};
			REG_MEM_CFG:  rdata_next = {30'h0, mem_cfg_reg};
			default:      rdata_next = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end
		else
		begin
			wait_reg  <= ~(bus_req & wait_reg);
			rdata_reg <= rdata_next;
		end
	end

	// Register writes; the single-start bit is a strobe and is not stored
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_one_reg <= CTRL_RST;
			ctrl_two_reg <= CTRL_RST;
			ptr_low_reg  <= CTRL_RST;
			ptr_high_reg <= CTRL_RST;
			ptr_page_reg <= CTRL_RST;
			mem_cfg_reg  <= MCFG_RST;
		end
		else
		begin
			if (wr_c1)
				ctrl_one_reg <= wbyte;
			if (wr_c2)
				ctrl_two_reg <= wbyte & ~(8'h01 << C2_SINGLE);
			if (bus_wr & (avs_req.address == REG_PTR_LOW))
				ptr_low_reg <= wbyte;
			if (bus_wr & (avs_req.address == REG_PTR_HIGH))
				ptr_high_reg <= wbyte;
			if (bus_wr & (avs_req.address == REG_PTR_PAGE))
				ptr_page_reg <= wbyte;
			if (bus_wr & (avs_req.address == REG_MEM_CFG))
				mem_cfg_reg <= wbyte[1:0];
		end
	end

	// Done flag: set on a plain conversion end or a finished run; set beats clear
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			done_reg <= 1'b0;
		else if (stop_now | (conv_end & ~dma_run_reg)) // [R14]
			done_reg <= 1'b1;
		else if (wr_st & wbyte[ST_DONE])
			done_reg <= 1'b0;
	end

	// ==========================================================
	// Converter clock: a one-cycle tick every div_val master cycles
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt_reg <= 6'h00;
			tick_reg    <= 1'b0;
		end
		else
		begin
			div_cnt_reg <= (div_cnt_reg >= div_val - 6'h01) ? 6'h00 : div_cnt_reg + 6'h01; // [R2]
			tick_reg    <= (div_cnt_reg >= div_val - 6'h01);
		end
	end

	// ==========================================================
	// Conversion timing and start bookkeeping
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			conv_active_reg <= 1'b0;
			tick_cnt_reg    <= 5'h00;
			pend_reg        <= 1'b0;
			free_run_reg    <= 1'b0;
			result_reg      <= 12'h000;
			conv_chan_reg   <= 4'h0;
		end
		else
		begin
			pend_reg <= want & ~conv_begin & ~stop_now;
			if (conv_end)
				result_reg <= adc_data;
			if (conv_begin)
			begin
				conv_active_reg <= 1'b1;
				tick_cnt_reg    <= 5'h00;
				if (dma_en)
					conv_chan_reg <= next_chan_reg; // [R17]
			end
			else if (conv_end)
				conv_active_reg <= 1'b0;
			else if (conv_active_reg & tick_reg)
				tick_cnt_reg <= tick_cnt_reg + 5'h01; // [R1]
			// A single start in DMA mode runs the list back to back
			if (stop_now | ~dma_en)
				free_run_reg <= 1'b0;
			else if (single_req)
				free_run_reg <= 1'b1; // [R7]
		end
	end

	// ==========================================================
	// DMA pipeline: fetch -> convert -> write, one stage per conversion
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dma_run_reg     <= 1'b0;
			conv_valid_reg  <= 1'b0;
			fetch_valid_reg <= 1'b0;
			wr_valid_reg    <= 1'b0;
			stop_seen_reg   <= 1'b0;
			next_chan_reg   <= 4'h0;
			wr_chan_reg     <= 4'h0;
			wr_res_reg      <= 12'h000;
			rd_addr_reg     <= 24'h0;
			wr_addr_reg     <= 24'h0;
		end
		else if (~dma_run_reg & ~dma_begin)
		begin
			// Idle: track the pointer, empty the pipeline
			conv_valid_reg  <= 1'b0;
			fetch_valid_reg <= 1'b0;
			wr_valid_reg    <= 1'b0;
			stop_seen_reg   <= 1'b0;
			rd_addr_reg     <= {ptr_page_reg, ptr_high_reg, ptr_low_reg};
			wr_addr_reg     <= {ptr_page_reg, ptr_high_reg, ptr_low_reg};
		end
		else
		begin
			if (stop_now)
				dma_run_reg <= 1'b0; // [R22]
			else if (dma_begin)
				dma_run_reg <= 1'b1;
			if (dma_begin)
			begin
				conv_valid_reg <= fetch_valid_reg; // [R17]
				wr_valid_reg   <= wr_now;
				wr_chan_reg    <= conv_chan_reg;
				wr_res_reg     <= fin_res;
			end
			if (mst_reg == M_WR_LO)
				wr_addr_reg <= wr_addr_reg + PTR_STEP;
			if (mst_reg == M_RD_WAIT)
			begin
				rd_addr_reg     <= rd_addr_reg + PTR_STEP;
				next_chan_reg   <= mem_rdata[7:4]; // [R10]
				fetch_valid_reg <= 1'b1;
				if (mem_rdata[7:4] == CHAN_STOP)
					stop_seen_reg <= 1'b1; // [R11]
			end
		end
	end

	// ==========================================================
	// Memory sequencer; strobes follow the registered state
	always_comb
	begin
		mst_next = mst_reg;
		case (mst_reg)
			M_IDLE:    if (dma_begin) mst_next = wr_now ? M_WR_HI : M_RD;
			M_WR_HI:   mst_next = M_WR_LO;
			M_WR_LO:   mst_next = M_RD;
			M_RD:      mst_next = M_RD_WAIT;
			M_RD_WAIT: mst_next = M_IDLE;
			default:   mst_next = M_IDLE;
		endcase
	end

	// Bus contents for the next state; stop-pattern cycle issues no further write
	always_comb
	begin
		mem_next          = '0;
		mem_next.internal = dma_int;
		case (mst_next)
			M_WR_HI:
			begin
				mem_next.we    = 1'b1;
				mem_next.addr  = wr_addr_reg;
				mem_next.wdata = wr_now ? {conv_chan_reg, fin_res[11:8]} // [R21]
				                        : {wr_chan_reg, wr_res_reg[11:8]};
			end
			M_WR_LO:
			begin
				mem_next.we    = 1'b1;
				mem_next.addr  = wr_addr_reg + 24'h000001;
				mem_next.wdata = wr_res_reg[7:0]; // [R21]
			end
			M_RD:
			begin
				mem_next.re   = 1'b1;
				mem_next.addr = rd_addr_reg;
			end
			M_RD_WAIT: mem_next.addr = rd_addr_reg;
			default:   mem_next.addr = 24'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mst_reg    <= M_IDLE;
			mem_reg    <= '0;
			ext_en_reg <= 1'b1;
			int_en_reg <= 1'b1;
		end
		else
		begin
			mst_reg    <= mst_next;
			mem_reg    <= mem_next;
			ext_en_reg <= ~(dma_run_reg & ~dma_int);                     // [R16] [R19]
			int_en_reg <= ~dma_run_reg | (mem_cfg_reg[MC_INT_EN] & ~dma_int); // [R20]
		end
	end

	// ==========================================================
	// Outputs
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign adc_channel     = conv_chan_reg;
	assign adc_busy        = conv_active_reg;
	assign mem             = mem_reg;
	assign core_ext_enable = ext_en_reg;
	assign core_int_enable = int_en_reg;

	// ==========================================================
	// Checks
	logic [1:0] cyc_cnt_reg;
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			cyc_cnt_reg <= 2'h0;
		else if (~dma_run_reg & ~dma_begin)
			cyc_cnt_reg <= 2'h0;
		else if (dma_begin & (cyc_cnt_reg != 2'h3))
			cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
	end

	sequence s_write_pair;
		mem_reg.we ##1 (mem_reg.we && mem_reg.addr == $past(mem_reg.addr) + 24'h000001);
	endsequence
	sequence s_after_pair;
		mem_reg.re && !mem_reg.we;
	endsequence

	chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
		tick_reg |=> !tick_reg [*3]) else $error("converter tick too frequent");
	chk_conv_length: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
		conv_end |-> tick_cnt_reg == 5'h0f + {3'h0, ctrl_one_reg[3:2]} + 5'h01)
		else $error("conversion length wrong");
	chk_cont_restart: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4]
		(conv_end && ctrl_two_reg[C2_CONT] && power_on && !stop_now && mst_reg == M_IDLE)
		|=> conv_active_reg && tick_cnt_reg == 5'h00) else $error("no immediate restart");
	chk_run_done: assert property (@(posedge sys_clk) disable iff (!resetn) // [R14]
		stop_now |=> done_reg && !dma_run_reg && !conv_active_reg) else $error("run end flag");
	chk_core_gated: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
		(dma_run_reg && !dma_int) |=> !core_ext_enable) else $error("core not gated");
	chk_int_access: assert property (@(posedge sys_clk) disable iff (!resetn) // [R20]
		(dma_run_reg && dma_int) |=> !core_int_enable && core_ext_enable)
		else $error("internal ram not owned");
	chk_result_pair: assert property (@(posedge sys_clk) disable iff (!resetn) // [R21]
		(mst_reg == M_WR_HI) |-> s_write_pair ##1 s_after_pair) else $error("bad result pair");
	chk_first_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18]
		mem_reg.we |-> cyc_cnt_reg == 2'h3) else $error("write before third cycle");
	chk_fetch_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [R17]
		dma_begin |-> ##[1:3] mem_reg.re) else $error("channel not fetched");
	chk_stop_quiet: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
		stop_now |=> !mem_reg.we && mst_reg == M_IDLE) else $error("write after stop");
	chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
		(bus_req && avs_waitrequest) |=> !avs_waitrequest) else $error("bus answer late");

endmodule : adc_dma_capture

// File: rtl/adc_dma_pkg.sv
// Constants, types and field layout for the converter capture block.
// Assumes a 125 MHz system clock and word-aligned Avalon-MM register access.
package adc_dma_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] REG_CTRL_ONE = 5'h00;
	localparam logic [4:0] REG_CTRL_TWO = 5'h04;
	localparam logic [4:0] REG_PTR_LOW  = 5'h08;
	localparam logic [4:0] REG_PTR_HIGH = 5'h0c;
	localparam logic [4:0] REG_PTR_PAGE = 5'h10;
	localparam logic [4:0] REG_STATUS   = 5'h14;
	localparam logic [4:0] REG_RESULT   = 5'h18;
	localparam logic [4:0] REG_MEM_CFG  = 5'h1c;

	// ==========================================================
	// Field positions and reset values
	localparam int C1_POWER   = 7;
	localparam int C1_DIV_LO  = 4;
	localparam int C1_ACQ_LO  = 2;
	localparam int C1_T2_EN   = 1;
	localparam int C1_EXT_EN  = 0;
	localparam int C2_DMA_EN  = 6;
	localparam int C2_CONT    = 5;
	localparam int C2_SINGLE  = 4;
	localparam int ST_DONE    = 0;
	localparam int ST_BUSY    = 1;
	localparam int ST_DMA     = 2;
	localparam int MC_INT_EN  = 0;
	localparam int MC_DMA_INT = 1;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] MCFG_RST = 2'h0;

	// ==========================================================
	// Timing counts in converter clocks, memory layout
	localparam logic [4:0]  APPROX_CLKS = 5'h0f;
	localparam logic [4:0]  SYNC_CLKS   = 5'h01;
	localparam logic [3:0]  CHAN_STOP   = 4'hf;
	localparam logic [23:0] PTR_STEP    = 24'h000002;

	// ==========================================================
	// Carriers and states
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avmm_req_t;

	typedef struct packed {
		logic        re;
		logic        we;
		logic        internal;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} mem_bus_t;

	typedef enum {M_IDLE, M_WR_HI, M_WR_LO, M_RD, M_RD_WAIT} mem_state_t;

	// Master clock cycles per converter clock for the divide field
	function automatic logic [5:0] div_ratio(input logic [1:0] sel);
		case (sel)
			2'h0:    div_ratio = 6'h08;
			2'h1:    div_ratio = 6'h04;
			2'h2:    div_ratio = 6'h10;
			default: div_ratio = 6'h20;
		endcase
	endfunction : div_ratio

endpackage : adc_dma_pkg

// File: verif/ext_sram_model.sv
// Behavioural static RAM on the capture block's memory bus.
// Assumes one strobe per cycle and read data wanted the cycle after the read strobe.
`timescale 1ns/1ps
module ext_sram_model
	import adc_dma_pkg::*;
(
	input  wire logic     sys_clk,
	input  wire mem_bus_t mem,
	output logic [7:0]    mem_rdata
);
	// ====================
	// Storage
	logic [7:0] store [logic [23:0]];
	int         wr_count = 0;
	logic       hold_reg = 1'b0;

	initial mem_rdata = 8'h00;

	// One byte stored per write strobe, counted so stray writes show up
	always @(posedge sys_clk)
	begin
		if (mem.we)
		begin
			store[mem.addr] = mem.wdata;
			wr_count = wr_count + 1;
		end
	end

	// Data valid for one cycle only, then scrambled so a late sample cannot pass
	always @(posedge sys_clk)
	begin
		hold_reg <= mem.re;
		if (mem.re)
			mem_rdata <= store.exists(mem.addr) ? store[mem.addr] : 8'h00;
		else if (hold_reg)
			mem_rdata <= ~mem_rdata;
	end
endmodule : ext_sram_model

// File: verif/test_adc_dma_capture.sv
// Self-checking bench for the converter capture block.
// Assumes the static RAM model on the memory side and a 125 MHz clock.
`timescale 1ns/1ps
module test_adc_dma_capture
	import adc_dma_pkg::*;
;
	// ====================
	// Signals
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	avmm_req_t   avs_req = '0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        timer2_overflow = 1'b0;
	logic        ext_trigger = 1'b0;
	logic [11:0] adc_data = 12'ha5c;
	logic [3:0]  adc_channel;
	logic        adc_busy;
	mem_bus_t    mem;
	logic [7:0]  mem_rdata;
	logic        core_ext_enable;
	logic        core_int_enable;
	int          err_total = 0;
	int          checks_done = 0;
	logic [31:0] rv;
	int          dv [4] = '{8, 4, 16, 32};

	// Clock
	always #4 sys_clk = ~sys_clk;

	adc_dma_capture i_adc_dma_capture (.sys_clk(sys_clk), .resetn(resetn), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timer2_overflow(timer2_overflow), .ext_trigger(ext_trigger), .adc_data(adc_data),
		.adc_channel(adc_channel), .adc_busy(adc_busy), .mem(mem), .mem_rdata(mem_rdata),
		.core_ext_enable(core_ext_enable), .core_int_enable(core_int_enable));

	ext_sram_model i_ext_sram_model (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));

	// ====================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Request held until waitrequest is sampled low, bounded so a hang cannot stall
	task automatic bus(input logic wr_n, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		avs_req.read <= !wr_n;
		avs_req.write <= wr_n;
		avs_req.address <= a;
		avs_req.byteenable <= 4'h1;
		avs_req.writedata <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 64);
		rv = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		check(n < 64, 1'b1);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
	endtask : rd

	task automatic wait_idle();
		for (int n = 0; n < 3000 && adc_busy !== 1'b0; n++)
			@(posedge sys_clk);
	endtask : wait_idle

	task automatic conclude();
		$display("counts: checks=%0d mismatches=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// ====================
	// Scenarios
	task automatic test_reset();
		check({avs_waitrequest, core_ext_enable, core_int_enable}, 3'h7);
		check({mem.re, mem.we, adc_busy, adc_channel}, 7'h00);
		rd(REG_CTRL_ONE);
		check(rv, 32'h0);
		wr(5'h03, 8'hff);
		rd(5'h03);
		check(rv, 32'h0);
		wr(REG_CTRL_ONE, 8'hb5);
		rd(REG_CTRL_ONE);
		check(rv, 32'hb5);
		wr(REG_CTRL_ONE, 8'h00);
		$display("test reset_regs finished");
	endtask : test_reset

	// Busy span per divide setting, acquisition field tied to the same index
	task automatic test_timing();
		int cnt;
		int exp;
		for (int s = 0; s < 4; s++)
		begin
			exp = (17 + s) * dv[s];
			adc_data <= 12'h3c5 ^ {s[1:0], 10'h000};
			wr(REG_CTRL_ONE, {2'b10, s[1:0], s[1:0], 2'b00});
			wr(REG_CTRL_TWO, 8'h10);
			for (int n = 0; n < 300 && adc_busy !== 1'b1; n++)
				@(posedge sys_clk);
			cnt = 0;
			while (adc_busy === 1'b1 && cnt < 2000)
			begin
				@(posedge sys_clk);
				cnt++;
			end
			check(cnt + dv[s] > exp && cnt < exp + dv[s] ? exp : cnt, exp);
			rd(REG_STATUS);
			check(rv[ST_DONE], 1'b1);
			rd(REG_RESULT);
			check(rv[11:0], adc_data);
			wr(REG_STATUS, 8'h01);
		end
		$display("test conv_timing finished");
	endtask : test_timing

	// A disabled trigger must not start; the enabled one must
	task automatic test_triggers();
		for (int t = 0; t < 2; t++)
		begin
			wr(REG_CTRL_ONE, t ? 8'h91 : 8'h92);
			timer2_overflow <= (t == 1);
			ext_trigger <= (t == 0);
			@(posedge sys_clk);
			timer2_overflow <= 1'b0;
			ext_trigger <= 1'b0;
			repeat (20) @(posedge sys_clk);
			check(adc_busy, 1'b0);
			timer2_overflow <= (t == 0);
			ext_trigger <= (t == 1);
			@(posedge sys_clk);
			timer2_overflow <= 1'b0;
			ext_trigger <= 1'b0;
			repeat (4) @(posedge sys_clk);
			check(adc_busy, 1'b1);
			wait_idle();
			wr(REG_STATUS, 8'h01);
		end
		$display("test triggers finished");
	endtask : test_triggers

	// Continuous mode chains conversions with no idle gap until it is switched off
	task automatic test_continuous();
		int gaps;
		wr(REG_CTRL_ONE, 8'h90);
		wr(REG_CTRL_TWO, 8'h30);
		gaps = 0;
		for (int n = 0; n < 300; n++)
		begin
			@(posedge sys_clk);
			if (n > 4 && adc_busy !== 1'b1)
				gaps++;
		end
		check(gaps, 0);
		rd(REG_STATUS);
		check(rv[2:0], 3'h3);
		wr(REG_CTRL_TWO, 8'h00);
		wait_idle();
		check(adc_busy, 1'b0);
		wr(REG_STATUS, 8'h01);
		$display("test continuous finished");
	endtask : test_continuous

	// Full list run; the final duplicate's result is never written, and its location is not judged
	task automatic test_dma(input logic [1:0] cfg);
		logic [3:0]  ids [4] = '{4'h3, 4'h5, 4'h5, 4'hf};
		logic [23:0] base = 24'h031240;
		int          n;
		for (int k = 0; k < 4; k++)
		begin
			i_ext_sram_model.store[base + 24'(2 * k)] = {ids[k], 4'h0};
			i_ext_sram_model.store[base + 24'(2 * k + 1)] = 8'hee;
		end
		i_ext_sram_model.wr_count = 0;
		wr(REG_CTRL_ONE, 8'h00);
		wr(REG_PTR_LOW, base[7:0]);
		wr(REG_PTR_HIGH, base[15:8]);
		wr(REG_PTR_PAGE, base[23:16]);
		wr(REG_MEM_CFG, {6'h00, cfg});
		wr(REG_CTRL_TWO, 8'h40);
		wr(REG_CTRL_ONE, 8'h90);
		wr(REG_CTRL_TWO, 8'h50);
		for (n = 0; n < 2000 && i_ext_sram_model.wr_count == 0; n++)
			@(posedge sys_clk);
		check(n > 100 && n < 250 ? 1 : n, 1);
		check({core_ext_enable, mem.internal}, {cfg[1], cfg[1]});
		check(core_int_enable, cfg == 2'h1);
		for (n = 0; n < 200; n++)
		begin
			rd(REG_STATUS);
			if (rv[ST_DONE] === 1'b1)
				break;
		end
		check(rv[ST_DONE], 1'b1);
		check(adc_channel, 4'h5);
		check(i_ext_sram_model.store[base], {4'h3, adc_data[11:8]});
		check(i_ext_sram_model.store[base + 24'h1], adc_data[7:0]);
		check(i_ext_sram_model.store[base + 24'h2], {4'h5, adc_data[11:8]});
		check(i_ext_sram_model.store[base + 24'h6], 8'hf0);
		check(i_ext_sram_model.store[base + 24'h7], 8'hee);
		n = i_ext_sram_model.wr_count;
		repeat (200) @(posedge sys_clk);
		check(i_ext_sram_model.wr_count, n);
		check({adc_busy, core_ext_enable, core_int_enable}, 3'h3);
		wr(REG_CTRL_TWO, 8'h00);
		wr(REG_CTRL_ONE, 8'h00);
		wr(REG_STATUS, 8'h01);
		$display("test dma_run cfg=%h finished", cfg);
	endtask : test_dma

	// ====================
	// Main sequence and watchdog
	initial
	begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		test_reset();
		test_timing();
		test_triggers();
		test_continuous();
		test_dma(2'h1);
		test_dma(2'h2);
		conclude();
	end

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		err_total++;
		conclude();
	end
endmodule : test_adc_dma_capture
